/* File: psar_top.sv */
`timescale 1ns/100ps
//
// Contract
// R1: Upper four event flags set on a rising edge of their status input.
// R2: Lower four event flags set on any change of their status input.
// R3: Reading the event flag register clears all eight flags.
// R4: Flags record events regardless of the interrupt mask bits.
// R5: Unmasked flags drive the active-low interrupt until read; masks reset zero.
// R6: With insert enabled, the programmed trace byte goes out; resets to 0xcc.
// R7: Trace byte is sent most significant bit first.
// R8: Failure alarm declared after twelve frames without three equal K1 bytes.
// R9: Failure alarm cleared once three consecutive frames carry equal K1.
// R10: New K1/K2 pair captured after three equal frames; sets change flag.
// R11: Each K1 and K2 register changes only to a different persisted value.
// R12: Failure change flag set on alarm declare or remove; cleared by read.
// R13: First S1 byte of each frame goes into the rx_sync_status_byte register.
// R14: S1 change flag set when S1 differs from last frame; cleared by read.
// R15: With S1 mask set, an S1 change raises the interrupt.
// R16: With APS mask set, a captured K1/K2 code raises the interrupt.
// R17: With failure mask set, any failure alarm change raises the interrupt.
// R18: Received bytes keep the first received bit in bit 7.
// R19: Receive registers and APS status read-only; APS masks read/write, reset zero.
// R20: Status inputs are synchronised before edge detection.
module psar_top import psar_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [NUM_PINS-1:0] pmd_status_input_i,
    output logic irq_out_n_o,
    input wire logic rx_frame_i,
    input wire logic [7:0] rx_k1_i,
    input wire logic [7:0] rx_k2_i,
    input wire logic [7:0] rx_s1_i,
    input wire logic trace_insert_enable_i,
    input wire logic tx_trace_slot_i,
    output logic tx_trace_valid_o,
    output logic tx_trace_bit_o
);
    logic [7:0] status_input_event_flag;
    logic [7:0] next_event_flag;
    logic [7:0] status_input_irq_mask;
    logic [7:0] tx_trace_byte;
    logic [7:0] rx_k1_code;
    logic [7:0] rx_k2_code;
    logic [7:0] rx_sync_status_byte;

    logic switch_byte_fail_irq_mask;
    logic aps_code_change_irq_mask;
    logic sync_msg_change_irq_mask;
    logic switch_byte_fail_state;
    logic switch_byte_fail_change_flag;
    logic aps_code_change_flag;
    logic sync_msg_change_flag;

    logic [NUM_PINS-1:0] pin_rise;
    logic [NUM_PINS-1:0] pin_chg;

    logic pair_upd;
    logic pair_hit;
    logic [15:0] pair_val;
    logic k1_upd;
    logic k1_hit;
    logic [7:0] k1_val;

    logic [3:0] fail_cnt;
    logic fail_event;
    logic code_capture;
    logic s1_change;

    logic rd_evt;
    logic rd_aps;
    logic wr_mask;
    logic wr_trace;
    logic wr_aps;
    logic [7:0] aps_view;
    logic [7:0] next_rdata;
    logic irq_pending;

    psar_tx_e tx_state;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit_idx;

    // Register port decode
    assign rd_evt = rd_i && psar_hit(addr_i, OFS_EVT);
    assign rd_aps = rd_i && psar_hit(addr_i, OFS_APS);
    assign wr_mask = wr_i && psar_hit(addr_i, OFS_MASK);
    assign wr_trace = wr_i && psar_hit(addr_i, OFS_TRACE);
    assign wr_aps = wr_i && psar_hit(addr_i, OFS_APS);

    // Status input synchroniser and edge detector
    psar_pin_sync u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(clk_en_i),
        .pin_i(pmd_status_input_i),
        .rise_o(pin_rise),
        .chg_o(pin_chg)
    );

    // Persistence on the K1/K2 pair
    psar_run_det #(
        .W(16)
    ) u_pair_det (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(clk_en_i),
        .frame_i(rx_frame_i),
        .data_i({rx_k1_i, rx_k2_i}),
        .upd_o(pair_upd),
        .hit_o(pair_hit),
        .val_o(pair_val)
    );

    // Persistence on K1 alone for the failure alarm
    psar_run_det #(
        .W(8)
    ) u_k1_det (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(clk_en_i),
        .frame_i(rx_frame_i),
        .data_i(rx_k1_i),
        .upd_o(k1_upd),
        .hit_o(k1_hit),
        .val_o(k1_val)
    );

    // Event flags: rising edges in the upper nibble, changes in the lower
    always_comb begin
        next_event_flag = status_input_event_flag;
        for (int i = 0; i < NUM_PINS; i++) begin
            next_event_flag[EVT_RISE_LSB+i] = psar_sticky(
                status_input_event_flag[EVT_RISE_LSB+i], pin_rise[i], rd_evt); // R1 R3
            next_event_flag[i] = psar_sticky(
                status_input_event_flag[i], pin_chg[i], rd_evt); // R2 R3
        end
    end

    // Flags never look at the mask
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            status_input_event_flag <= RST_EVT;
        end else if (clk_en_i) begin
            status_input_event_flag <= next_event_flag; // R4
        end
    end

    // Software-written registers
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            status_input_irq_mask <= RST_MASK; // R5
            tx_trace_byte <= RST_TRACE; // R6
            switch_byte_fail_irq_mask <= 1'b0; // R19
            aps_code_change_irq_mask <= 1'b0;
            sync_msg_change_irq_mask <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_mask) begin
                status_input_irq_mask <= wdata_i;
            end
            if (wr_trace) begin
                tx_trace_byte <= wdata_i;
            end
            if (wr_aps) begin
                switch_byte_fail_irq_mask <= wdata_i[APS_PSBF_EN]; // R19
                aps_code_change_irq_mask <= wdata_i[APS_COAPS_EN];
                sync_msg_change_irq_mask <= wdata_i[APS_S1_EN];
            end
        end
    end

    // New code only when the persisted pair differs from what is held
    assign code_capture = pair_hit
        && pair_val != {rx_k1_code, rx_k2_code}; // R10

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rx_k1_code <= RST_RX;
            rx_k2_code <= RST_RX;
        end else if (clk_en_i) begin
            if (code_capture) begin
                if (pair_val[15:8] != rx_k1_code) begin
                    rx_k1_code <= pair_val[15:8]; // R11 R18
                end
                if (pair_val[7:0] != rx_k2_code) begin
                    rx_k2_code <= pair_val[7:0]; // R11 R18
                end
            end
        end
    end

    // Failure alarm: counts frames since K1 last held for three frames
    assign fail_event = k1_upd && (k1_hit
        ? switch_byte_fail_state
        : (!switch_byte_fail_state && fail_cnt == FAIL_FRAMES - 4'd1));

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            fail_cnt <= 4'd0;
            switch_byte_fail_state <= 1'b0;
        end else if (clk_en_i) begin
            if (k1_upd) begin
                if (k1_hit) begin
                    fail_cnt <= 4'd0;
                    switch_byte_fail_state <= 1'b0; // R9
                end else begin
                    if (fail_cnt != FAIL_FRAMES) begin
                        fail_cnt <= fail_cnt + 4'd1;
                    end
                    if (fail_cnt == FAIL_FRAMES - 4'd1) begin
                        switch_byte_fail_state <= 1'b1; // R8
                    end
                end
            end
        end
    end

    // Sync status byte taken every frame
    assign s1_change = rx_frame_i && rx_s1_i != rx_sync_status_byte; // R14

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rx_sync_status_byte <= RST_RX;
        end else if (clk_en_i) begin
            if (rx_frame_i) begin
                rx_sync_status_byte <= rx_s1_i; // R13 R18
            end
        end
    end

    // APS change flags, cleared by a status read
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            aps_code_change_flag <= 1'b0;
            switch_byte_fail_change_flag <= 1'b0;
            sync_msg_change_flag <= 1'b0;
        end else if (clk_en_i) begin
            aps_code_change_flag <= psar_sticky(
                aps_code_change_flag, code_capture, rd_aps); // R10
            switch_byte_fail_change_flag <= psar_sticky(
                switch_byte_fail_change_flag, fail_event, rd_aps); // R12
            sync_msg_change_flag <= psar_sticky(
                sync_msg_change_flag, s1_change, rd_aps); // R14
        end
    end

    // Read view of the APS register; unused bit reads zero
    always_comb begin
        aps_view = 8'h00;
        aps_view[APS_PSBF_EN] = switch_byte_fail_irq_mask;
        aps_view[APS_COAPS_EN] = aps_code_change_irq_mask;
        aps_view[APS_S1_EN] = sync_msg_change_irq_mask;
        aps_view[APS_S1_FLAG] = sync_msg_change_flag;
        aps_view[APS_PSBF_FLAG] = switch_byte_fail_change_flag;
        aps_view[APS_COAPS_FLAG] = aps_code_change_flag;
        aps_view[APS_PSBF_STATE] = switch_byte_fail_state;
    end

    always_comb begin
        case (addr_i)
            OFS_EVT: begin
                next_rdata = status_input_event_flag;
            end
            OFS_MASK: begin
                next_rdata = status_input_irq_mask;
            end
            OFS_TRACE: begin
                next_rdata = tx_trace_byte;
            end
            OFS_APS: begin
                next_rdata = aps_view;
            end
            OFS_K1: begin
                next_rdata = rx_k1_code; // R19
            end
            OFS_K2: begin
                next_rdata = rx_k2_code;
            end
            OFS_S1: begin
                next_rdata = rx_sync_status_byte;
            end
            default: begin
                next_rdata = RD_IDLE;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= RD_IDLE;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? next_rdata : RD_IDLE;
        end
    end

    // Interrupt from pending flags gated by their masks
    assign irq_pending = (|(status_input_event_flag & status_input_irq_mask)) // R5
        || (sync_msg_change_flag && sync_msg_change_irq_mask) // R15
        || (aps_code_change_flag && aps_code_change_irq_mask) // R16
        || (switch_byte_fail_change_flag && switch_byte_fail_irq_mask); // R17

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_out_n_o <= 1'b1;
        end else if (clk_en_i) begin
            irq_out_n_o <= ~irq_pending;
        end
    end

    // Trace byte serialiser, most significant bit first
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tx_state <= PSAR_TX_IDLE;
            tx_shift <= 8'h00;
            tx_bit_idx <= 3'd0;
            tx_trace_valid_o <= 1'b0;
            tx_trace_bit_o <= 1'b0;
        end else if (clk_en_i) begin
            case (tx_state)
                PSAR_TX_IDLE: begin
                    tx_trace_valid_o <= 1'b0;
                    tx_trace_bit_o <= 1'b0;
                    if (tx_trace_slot_i && trace_insert_enable_i) begin
                        tx_state <= PSAR_TX_SHIFT; // R6
                        tx_shift <= {tx_trace_byte[6:0], 1'b0};
                        tx_bit_idx <= 3'd0;
                        tx_trace_valid_o <= 1'b1;
                        tx_trace_bit_o <= tx_trace_byte[7]; // R7
                    end
                end
                PSAR_TX_SHIFT: begin
                    if (tx_bit_idx == TRACE_LAST_BIT - 3'd1) begin
                        tx_state <= PSAR_TX_IDLE;
                    end
                    tx_bit_idx <= tx_bit_idx + 3'd1;
                    tx_trace_bit_o <= tx_shift[7]; // R7
                    tx_shift <= {tx_shift[6:0], 1'b0};
                    tx_trace_valid_o <= 1'b1;
                end
                default: begin
                    tx_state <= PSAR_TX_IDLE;
                    tx_trace_valid_o <= 1'b0;
                    tx_trace_bit_o <= 1'b0;
                end
            endcase
        end
    end

    // K1 alone is used only for its run; its value is not kept
    logic unused_k1;
    logic unused_pair;
    assign unused_k1 = ^k1_val;
    assign unused_pair = pair_upd;
endmodule

/* File: psar_pkg.sv */
package psar_pkg;

    // Register offsets on the processor port
    localparam logic [7:0] OFS_EVT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h09;
    localparam logic [7:0] OFS_TRACE = 8'h0a;
    localparam logic [7:0] OFS_APS = 8'h0b;
    localparam logic [7:0] OFS_K1 = 8'h0c;
    localparam logic [7:0] OFS_K2 = 8'h0d;
    localparam logic [7:0] OFS_S1 = 8'h0e;

    // Reset values
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_TRACE = 8'hcc;
    localparam logic [7:0] RST_RX = 8'h00;
    localparam logic [7:0] RST_EVT = 8'h00;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Field positions in the APS control and status register
    localparam int unsigned APS_PSBF_EN = 7;
    localparam int unsigned APS_COAPS_EN = 6;
    localparam int unsigned APS_S1_EN = 5;
    localparam int unsigned APS_S1_FLAG = 4;
    localparam int unsigned APS_PSBF_FLAG = 3;
    localparam int unsigned APS_COAPS_FLAG = 2;
    localparam int unsigned APS_PSBF_STATE = 0;

    // Status input event flag layout
    localparam int unsigned NUM_PINS = 4;
    localparam int unsigned EVT_RISE_LSB = 4;

    // Frame counts
    localparam logic [1:0] PERSIST_FRAMES = 2'd3;
    localparam logic [3:0] FAIL_FRAMES = 4'd12;

    // Trace byte serialiser
    localparam logic [2:0] TRACE_LAST_BIT = 3'd7;

    typedef enum logic [1:0] {
        PSAR_TX_IDLE = 2'b01,
        PSAR_TX_SHIFT = 2'b10
    } psar_tx_e;

    // Sticky flag update: a set in the clearing cycle wins
    function automatic logic psar_sticky(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    function automatic logic psar_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

endpackage

/* File: psar_pin_sync.sv */
`timescale 1ns/100ps
module psar_pin_sync import psar_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [NUM_PINS-1:0] pin_i,
    output logic [NUM_PINS-1:0] rise_o,
    output logic [NUM_PINS-1:0] chg_o
);
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] stable;
    logic [NUM_PINS-1:0] next_stable;

    // A new level counts only once the second and third stage agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_stable[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            meta <= '0;
            sync2 <= '0;
            sync3 <= '0;
            stable <= '0;
            rise_o <= '0;
            chg_o <= '0;
        end else if (ce_i) begin
            meta <= pin_i; // R20
            sync2 <= meta;
            sync3 <= sync2;
            stable <= next_stable;
            rise_o <= next_stable & ~stable;
            chg_o <= next_stable ^ stable;
        end
    end
endmodule

/* File: psar_run_det.sv */
`timescale 1ns/100ps
module psar_run_det import psar_pkg::*; #(
    parameter int unsigned W = 8
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic frame_i,
    input wire logic [W-1:0] data_i,
    output logic upd_o,
    output logic hit_o,
    output logic [W-1:0] val_o
);
    logic [W-1:0] last;
    logic [1:0] run;
    logic [1:0] next_run;

    // Consecutive identical frames, saturating at the persistence count
    always_comb begin
        if (run != 2'd0 && data_i == last) begin
            next_run = (run == PERSIST_FRAMES) ? run : run + 2'd1;
        end else begin
            next_run = 2'd1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            last <= '0;
            run <= 2'd0;
            upd_o <= 1'b0;
            hit_o <= 1'b0;
            val_o <= '0;
        end else if (ce_i) begin
            upd_o <= frame_i;
            hit_o <= frame_i && next_run == PERSIST_FRAMES;
            if (frame_i) begin
                last <= data_i;
                run <= next_run;
                val_o <= data_i;
            end
        end
    end
endmodule

/* File: psar_top_monitor.sv */
`timescale 1ns/100ps
module psar_top_monitor import psar_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [NUM_PINS-1:0] pmd_status_input_i,
    input wire logic irq_out_n_o,
    input wire logic rx_frame_i,
    input wire logic [7:0] rx_k1_i,
    input wire logic [7:0] rx_k2_i,
    input wire logic [7:0] rx_s1_i,
    input wire logic trace_insert_enable_i,
    input wire logic tx_trace_slot_i,
    input wire logic tx_trace_valid_o,
    input wire logic tx_trace_bit_o
);
    logic [7:0] trace_q;
    logic [7:0] mask_q;
    logic [7:0] s1_q;
    logic [7:0] sh;
    logic [2:0] aps_q;
    logic mask_any;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    // Shadow copies of what software wrote and what the line sent
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            trace_q <= RST_TRACE;
            mask_q <= RST_MASK;
            aps_q <= 3'h0;
            s1_q <= RST_RX;
            mask_any <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_i && addr_i == OFS_TRACE) begin
                trace_q <= wdata_i;
            end
            if (wr_i && addr_i == OFS_MASK) begin
                mask_q <= wdata_i;
            end
            if (wr_i && addr_i == OFS_APS) begin
                aps_q <= wdata_i[7:5];
            end
            if (rx_frame_i) begin
                s1_q <= rx_s1_i;
            end
            if (wr_i && ((addr_i == OFS_MASK && wdata_i != 8'h00) ||
                    (addr_i == OFS_APS && wdata_i[7:5] != 3'h0))) begin
                mask_any <= 1'b1;
            end
        end
    end

    // Expected serial trace bits, loaded on an accepted slot
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sh <= 8'h00;
        end else if (clk_en_i) begin
            if (tx_trace_slot_i && trace_insert_enable_i && !tx_trace_valid_o) begin
                sh <= trace_q;
            end else if (tx_trace_valid_o) begin
                sh <= {sh[6:0], 1'b0};
            end
        end
    end

    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        rd_i && (addr_i < OFS_EVT || addr_i > OFS_S1) |=> rdata_o == RD_IDLE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_trace_rb;
        rd_i && addr_i == OFS_TRACE |=> rdata_o == trace_q;
    endproperty
    a_trace_rb: assert property (p_trace_rb) else $error("trace byte readback");
    property p_mask_rb;
        rd_i && addr_i == OFS_MASK |=> rdata_o == mask_q;
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
    property p_aps_rb;
        rd_i && addr_i == OFS_APS |=> rdata_o[7:5] == aps_q;
    endproperty
    a_aps_rb: assert property (p_aps_rb) else $error("aps mask readback");
    property p_s1_rb;
        rd_i && addr_i == OFS_S1 && !rx_frame_i && !$past(rx_frame_i) |=> rdata_o == s1_q;
    endproperty
    a_s1_rb: assert property (p_s1_rb) else $error("s1 register wrong");
    property p_irq_quiet;
        !mask_any |-> irq_out_n_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with all masks zero");
    property p_trace_len;
        $rose(tx_trace_valid_o) |-> tx_trace_valid_o [*8] ##1 !tx_trace_valid_o;
    endproperty
    a_trace_len: assert property (p_trace_len) else $error("trace burst length");
    property p_trace_bit;
        tx_trace_valid_o |-> tx_trace_bit_o == sh[7];
    endproperty
    a_trace_bit: assert property (p_trace_bit) else $error("trace bit order");
    property p_trace_off;
        !trace_insert_enable_i && tx_trace_slot_i && !tx_trace_valid_o |=> !tx_trace_valid_o;
    endproperty
    a_trace_off: assert property (p_trace_off) else $error("trace sent while off");
endmodule

bind psar_top psar_top_monitor u_mon (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pmd_status_input_i(pmd_status_input_i), .irq_out_n_o(irq_out_n_o),
    .rx_frame_i(rx_frame_i), .rx_k1_i(rx_k1_i), .rx_k2_i(rx_k2_i), .rx_s1_i(rx_s1_i),
    .trace_insert_enable_i(trace_insert_enable_i), .tx_trace_slot_i(tx_trace_slot_i),
    .tx_trace_valid_o(tx_trace_valid_o), .tx_trace_bit_o(tx_trace_bit_o)
);

/* File: psar_peer.sv */
`timescale 1ns/100ps
module psar_peer import psar_pkg::*; (
    input wire logic sys_clk_i,
    output logic [NUM_PINS-1:0] pins_o,
    output logic frame_o,
    output logic [7:0] k1_o,
    output logic [7:0] k2_o,
    output logic [7:0] s1_o
);
    initial begin
        pins_o = '0;
        frame_o = 1'b0;
        k1_o = 8'h00;
        k2_o = 8'h00;
        s1_o = 8'h00;
    end

    // Status lines move off the clock edge, as a real module would
    task automatic set_pins(input logic [NUM_PINS-1:0] v);
        @(posedge sys_clk_i);
        #3;
        pins_o = v;
    endtask

    // One frame; bytes are inverted afterwards so stale values never match
    task automatic send(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] s1);
        @(posedge sys_clk_i);
        frame_o <= 1'b1;
        k1_o <= k1;
        k2_o <= k2;
        s1_o <= s1;
        @(posedge sys_clk_i);
        frame_o <= 1'b0;
        k1_o <= ~k1;
        k2_o <= ~k2;
        s1_o <= ~s1;
        repeat (2) @(posedge sys_clk_i);
    endtask
endmodule

/* File: psar_top_tb_top.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module psar_top_tb_top import psar_pkg::*;;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ten = 1'b0;
    logic slot = 1'b0;
    logic [7:0] rdata_o;
    logic irq_n;
    logic tvalid;
    logic tbit;
    logic [NUM_PINS-1:0] pins;
    logic frame;
    logic [7:0] k1;
    logic [7:0] k2;
    logic [7:0] s1;
    int n_tests = 0;
    int n_mismatch = 0;
    int cyc = 0;
    logic [7:0] rofs [8] = '{OFS_EVT, OFS_MASK, OFS_TRACE, OFS_APS, OFS_K1, OFS_K2, OFS_S1, 8'h0f};
    logic [7:0] rval [8] = '{8'h00, 8'h00, 8'hcc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    psar_top dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pmd_status_input_i(pins), .irq_out_n_o(irq_n), .rx_frame_i(frame),
        .rx_k1_i(k1), .rx_k2_i(k2), .rx_s1_i(s1), .trace_insert_enable_i(ten),
        .tx_trace_slot_i(slot), .tx_trace_valid_o(tvalid), .tx_trace_bit_o(tbit)
    );
    psar_peer peer (
        .sys_clk_i(sys_clk_i), .pins_o(pins), .frame_o(frame), .k1_o(k1), .k2_o(k2),
        .s1_o(s1)
    );

    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            end_sim;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic slot_pulse;
        @(posedge sys_clk_i);
        slot <= 1'b1;
        @(posedge sys_clk_i);
        slot <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(rofs[i], rval[i]);
        `CHK(irq_n, 1'b1)
        wr(OFS_MASK, 8'ha5);
        rdc(OFS_MASK, 8'ha5);
        wr(OFS_APS, 8'hff);
        rdc(OFS_APS, 8'he0);
        wr(OFS_K1, 8'hff);
        rdc(OFS_K1, 8'h00);
        wr(OFS_EVT, 8'hff);
        rdc(OFS_EVT, 8'h00);
        wr(OFS_MASK, 8'h00);
        wr(OFS_APS, 8'h00);
        $display("test registers done");
        wr(OFS_TRACE, 8'h96);
        rdc(OFS_TRACE, 8'h96);
        slot_pulse();
        `CHK(tvalid, 1'b0)
        @(posedge sys_clk_i) ten <= 1'b1;
        slot_pulse();
        for (int i = 7; i >= 0; i--) begin
            `CHK({tvalid, tbit}, {1'b1, 1'(8'h96 >> i)})
            wait_cyc(1);
        end
        `CHK(tvalid, 1'b0)
        $display("test trace done");
        peer.set_pins(4'h9);
        wait_cyc(8);
        `CHK(irq_n, 1'b1)
        rdc(OFS_EVT, 8'h99);
        peer.set_pins(4'h8);
        wait_cyc(8);
        rdc(OFS_EVT, 8'h01);
        rdc(OFS_EVT, 8'h00);
        wr(OFS_MASK, 8'h10);
        clk_en_i <= 1'b0;
        peer.set_pins(4'h9);
        wait_cyc(8);
        `CHK(irq_n, 1'b1)
        @(posedge sys_clk_i) clk_en_i <= 1'b1;
        wait_cyc(8);
        `CHK(irq_n, 1'b0)
        rdc(OFS_EVT, 8'h11);
        wait_cyc(2);
        `CHK(irq_n, 1'b1)
        wr(OFS_MASK, 8'h00);
        peer.set_pins(4'h0);
        wait_cyc(8);
        rdc(OFS_EVT, 8'h09);
        $display("test status inputs done");
        peer.send(8'h00, 8'h00, 8'h5a);
        rdc(OFS_S1, 8'h5a);
        rdc(OFS_APS, 8'h10);
        peer.send(8'h00, 8'h00, 8'h5a);
        rdc(OFS_APS, 8'h00);
        peer.send(8'h12, 8'h34, 8'h5a);
        peer.send(8'h12, 8'h34, 8'h5a);
        peer.send(8'h56, 8'h34, 8'h5a);
        peer.send(8'h12, 8'h34, 8'h5a);
        peer.send(8'h12, 8'h34, 8'h5a);
        rdc(OFS_K1, 8'h00);
        wr(OFS_APS, 8'h40);
        peer.send(8'h12, 8'h34, 8'h5a);
        wait_cyc(2);
        `CHK(irq_n, 1'b0)
        rdc(OFS_K1, 8'h12);
        rdc(OFS_K2, 8'h34);
        rdc(OFS_APS, 8'h44);
        wr(OFS_APS, 8'h20);
        peer.send(8'h12, 8'h34, 8'h3c);
        wait_cyc(2);
        `CHK(irq_n, 1'b0)
        rdc(OFS_APS, 8'h30);
        $display("test aps capture done");
        wr(OFS_APS, 8'h80);
        for (int i = 1; i < 12; i++) peer.send(8'(i), 8'h34, 8'h3c);
        rdc(OFS_APS, 8'h80);
        `CHK(irq_n, 1'b1)
        peer.send(8'h0c, 8'h34, 8'h3c);
        wait_cyc(2);
        `CHK(irq_n, 1'b0)
        rdc(OFS_APS, 8'h89);
        peer.send(8'h0c, 8'h34, 8'h3c);
        peer.send(8'h0c, 8'h34, 8'h3c);
        rdc(OFS_APS, 8'h8c);
        rdc(OFS_K1, 8'h0c);
        $display("test alarm done");
        end_sim;
    end
endmodule
